// File: rtl/cocd_pkg.sv
/*
 * cocd_pkg: shared types and constants of the opcode cycle decoder.
 * assumes: consumers import the whole package; no clock or reset here.
 */
package cocd_pkg;

    // widths
    localparam int CYC_W  = 6;
    localparam int LEN_W  = 3;
    localparam int CODE_W = 4;

    // instruction forms handled by the decoder
    typedef enum logic [3:0] {
        FORM_DECIMAL_ADD_RR,
        FORM_DECIMAL_SUB_RR,
        FORM_DECIMAL_SUB_BORROW_RR,
        FORM_DECIMAL_SUB_IMM,
        FORM_DECIMAL_SUB_BORROW_IMM,
        FORM_FRAME_ALLOC_IMM8,
        FORM_DECREMENT_OP_B,
        FORM_DECREMENT_OP_W,
        FORM_SIGNED_DIVIDE_IMM,
        FORM_SIGNED_DIVIDE_SRC,
        FORM_EXT_SIGN_DIVIDE_IMM,
        FORM_EXT_SIGN_DIVIDE_SRC,
        FORM_UNSIGNED_DIVIDE_IMM,
        FORM_UNSIGNED_DIVIDE_SRC,
        FORM_FRAME_RELEASE_RETURN,
        FORM_SIGN_EXTEND_OP_B
    } cocd_form_e;

    // operand kinds
    typedef enum logic [3:0] {
        OPK_NONE,
        OPK_DATA_REG,
        OPK_ADDR_REG,
        OPK_INDIRECT,
        OPK_DSP8_ADDR,
        OPK_DSP8_STATIC_BASE,
        OPK_DSP8_FRAME_BASE,
        OPK_DSP16_ADDR,
        OPK_DSP16_STATIC_BASE,
        OPK_ABS16,
        OPK_ACC_HIGH_BYTE,
        OPK_ACC_LOW_BYTE,
        OPK_AUX_LOW_BYTE
    } cocd_opk_e;

    typedef enum logic {
        ST_IDLE,
        ST_RUN
    } cocd_state_e;

    typedef struct packed {
        logic              valid;
        cocd_form_e        form;
        logic              size_w;
        logic [CODE_W-1:0] code;
    } cocd_req_s;

    typedef struct packed {
        cocd_opk_e  kind;
        logic [1:0] reg_sel;
        logic [1:0] ext_bytes;
    } cocd_opnd_s;

    typedef struct packed {
        cocd_form_e       form;
        cocd_opnd_s       opnd;
        logic [LEN_W-1:0] len;
        logic [CYC_W-1:0] cycles;
        logic             undef;
        logic             is_div;
    } cocd_dcd_s;

    // general operand field boundaries
    localparam logic [CODE_W-1:0] OPC_ADDR_FIRST   = 4'h4;
    localparam logic [CODE_W-1:0] OPC_IND_FIRST    = 4'h6;
    localparam logic [CODE_W-1:0] OPC_DSP8_FIRST   = 4'h8;
    localparam logic [CODE_W-1:0] OPC_DSP8_STATIC  = 4'hA;
    localparam logic [CODE_W-1:0] OPC_DSP8_FRAME   = 4'hB;
    localparam logic [CODE_W-1:0] OPC_DSP16_STATIC = 4'hE;
    localparam logic [CODE_W-1:0] OPC_ABS16        = 4'hF;
    // sign extension register codes
    localparam logic [CODE_W-1:0] OPC_ACC_LOW      = 4'h0;
    localparam logic [CODE_W-1:0] OPC_AUX_LOW      = 4'h2;
    // byte decrement destination codes
    localparam logic [2:0] DCC_ACC_HIGH     = 3'h3;
    localparam logic [2:0] DCC_ACC_LOW      = 3'h4;
    localparam logic [2:0] DCC_DSP8_STATIC  = 3'h5;
    localparam logic [2:0] DCC_DSP8_FRAME   = 3'h6;
    localparam logic [2:0] DCC_ABS16        = 3'h7;

    // byte lengths
    localparam logic [LEN_W-1:0] LEN_RR        = 3'h2;
    localparam logic [LEN_W-1:0] LEN_IMM8      = 3'h3;
    localparam logic [LEN_W-1:0] LEN_IMM16     = 3'h4;
    localparam logic [LEN_W-1:0] LEN_DECR_REG  = 3'h1;
    localparam logic [LEN_W-1:0] LEN_DECR_DSP  = 3'h2;
    localparam logic [LEN_W-1:0] LEN_DECR_ABS  = 3'h3;
    localparam logic [LEN_W-1:0] LEN_GEN_BASE  = 3'h2;
    localparam logic [LEN_W-1:0] LEN_DIV_IMM   = 3'h3;
    localparam logic [LEN_W-1:0] LEN_WORD_ADD  = 3'h1;
    localparam logic [LEN_W-1:0] LEN_EXIT      = 3'h2;

    // cycle counts
    localparam logic [CYC_W-1:0] CYC_DEC_ADD      = 6'h05;
    localparam logic [CYC_W-1:0] CYC_DEC_SUB      = 6'h04;
    localparam logic [CYC_W-1:0] CYC_FRAME_ALLOC  = 6'h04;
    localparam logic [CYC_W-1:0] CYC_DECR_REG     = 6'h01;
    localparam logic [CYC_W-1:0] CYC_DECR_MEM     = 6'h03;
    localparam logic [CYC_W-1:0] CYC_SDIV_REG     = 6'h16;
    localparam logic [CYC_W-1:0] CYC_SDIV_MEM     = 6'h18;
    localparam logic [CYC_W-1:0] CYC_SDIV_IMM     = 6'h16;
    localparam logic [CYC_W-1:0] CYC_SDIV_W_ADD   = 6'h06;
    localparam logic [CYC_W-1:0] CYC_UDIV_REG     = 6'h12;
    localparam logic [CYC_W-1:0] CYC_UDIV_MEM     = 6'h14;
    localparam logic [CYC_W-1:0] CYC_UDIV_IMM     = 6'h12;
    localparam logic [CYC_W-1:0] CYC_UDIV_W_ADD   = 6'h07;
    localparam logic [CYC_W-1:0] CYC_EXIT         = 6'h09;
    localparam logic [CYC_W-1:0] CYC_SEXT_REG     = 6'h03;
    localparam logic [CYC_W-1:0] CYC_SEXT_MEM     = 6'h05;

endpackage : cocd_pkg

// File: rtl/cocd_operand_map.sv
/*
 * cocd_operand_map: decodes a 4-bit operand field into an operand kind.
 * assumes: purely combinational; the instantiating module registers it.
 */
`timescale 1ns/10ps
`default_nettype none

module cocd_operand_map #(
    parameter bit SIGN_EXT_MAP = 1'b0
) (
    input  wire logic [cocd_pkg::CODE_W-1:0] code_i,
    output cocd_pkg::cocd_opnd_s            opnd_o,
    output logic                            undef_o
);
    import cocd_pkg::*;

    always_comb
    begin
        opnd_o  = '{kind: OPK_NONE, reg_sel: 2'h0, ext_bytes: 2'h0};
        undef_o = 1'b0;
        if (code_i < OPC_ADDR_FIRST)
        begin
            opnd_o.kind    = OPK_DATA_REG;
            opnd_o.reg_sel = code_i[1:0];
        end
        else if (code_i < OPC_IND_FIRST)
        begin
            opnd_o.kind    = OPK_ADDR_REG;
            opnd_o.reg_sel = {1'b0, code_i[0]};
        end
        else if (code_i < OPC_DSP8_FIRST)
        begin
            opnd_o.kind    = OPK_INDIRECT;
            opnd_o.reg_sel = {1'b0, code_i[0]};
        end
        else if (code_i < OPC_DSP8_STATIC)
        begin
            opnd_o.kind      = OPK_DSP8_ADDR;
            opnd_o.reg_sel   = {1'b0, code_i[0]};
            opnd_o.ext_bytes = 2'h1;
        end
        else if (code_i == OPC_DSP8_STATIC)
        begin
            opnd_o.kind      = OPK_DSP8_STATIC_BASE;
            opnd_o.ext_bytes = 2'h1;
        end
        else if (code_i == OPC_DSP8_FRAME)
        begin
            opnd_o.kind      = OPK_DSP8_FRAME_BASE;
            opnd_o.ext_bytes = 2'h1;
        end
        else if (code_i < OPC_DSP16_STATIC)
        begin
            opnd_o.kind      = OPK_DSP16_ADDR;
            opnd_o.reg_sel   = {1'b0, code_i[0]};
            opnd_o.ext_bytes = 2'h2;
        end
        else if (code_i == OPC_DSP16_STATIC)
        begin
            opnd_o.kind      = OPK_DSP16_STATIC_BASE;
            opnd_o.ext_bytes = 2'h2;
        end
        else
        begin
            opnd_o.kind      = OPK_ABS16;
            opnd_o.ext_bytes = 2'h2;
        end

        // sign extension map: codes below 6 give one of two byte registers or undefined, rest as general
        if (SIGN_EXT_MAP && code_i < OPC_IND_FIRST)
        begin
            opnd_o.reg_sel = 2'h0;
            if (code_i == OPC_ACC_LOW)
                opnd_o.kind = OPK_ACC_LOW_BYTE;
            else if (code_i == OPC_AUX_LOW)
                opnd_o.kind = OPK_AUX_LOW_BYTE;
            else
            begin
                opnd_o.kind = OPK_NONE;
                undef_o     = 1'b1;
            end
        end
    end

endmodule : cocd_operand_map

`default_nettype wire

// File: rtl/cocd_decoder.sv
/*
 * cocd_decoder: decodes forms of decimal, decrement, divide, frame and
 * sign extension instructions into operand, byte length and cycle count,
 * then paces execution with a cycle counter.
 * assumes: requests come from logic on core_clk_i; rst_i is synchronous.
 */
// Contract
// - decimal add register forms: 2 bytes, 5 cycles
// - decimal subtract register forms: 2 bytes, 4 cycles
// - word immediate decimal subtracts: 4 bytes, 4 cycles
// - frame alloc, byte immediate subtracts: 3/4
// - byte decrement 3-bit destination code map
// - byte decrement lengths: 1/1, 2/3, 3/3
// - general 4-bit operand field decode
// - byte signed divide: register 22, memory 24
// - word signed divides add 6 cycles
// - immediate signed divides 3/22, word +1/+6
// - immediate unsigned divide 3/18, word +1/+7
// - unsigned divide register 18, memory 20, word +7
// - divides may finish early
// - sign extend accepts only two byte registers
// - frame release and return: 2 bytes, 9 cycles
// - sign extend map codes 0000/0010, 0110 up general
`timescale 1ns/10ps
`default_nettype none

module cocd_decoder (
    input  wire logic                        core_clk_i,
    input  wire logic                        rst_i,
    input  wire cocd_pkg::cocd_req_s         req_i,
    input  wire logic                        early_stop_i,
    output logic                             busy_o,
    output logic                             accept_o,
    output logic                             done_o,
    output logic                             early_o,
    output cocd_pkg::cocd_dcd_s              dcd_o,
    output logic [cocd_pkg::CYC_W-1:0]       remain_o
);
    import cocd_pkg::*;

    typedef struct packed {
        cocd_state_e      st;
        logic [CYC_W-1:0] cnt;
        cocd_dcd_s        res;
        logic             accept;
        logic             done;
        logic             early;
    } cocd_state_s;

    cocd_state_s s_q;
    cocd_state_s s_d;
    cocd_opnd_s  gen_opnd;
    cocd_opnd_s  sext_opnd;
    logic        gen_undef;
    logic        sext_undef;
    cocd_dcd_s   dcd;
    logic        gen_mem;
    logic        sext_mem;

    // general operand field
    cocd_operand_map #(
        .SIGN_EXT_MAP (1'b0)
    ) u_gen_map (
        .code_i  (req_i.code),
        .opnd_o  (gen_opnd),
        .undef_o (gen_undef)
    );

    // sign extension operand field
    cocd_operand_map #(
        .SIGN_EXT_MAP (1'b1)
    ) u_sext_map (
        .code_i  (req_i.code),
        .opnd_o  (sext_opnd),
        .undef_o (sext_undef)
    );

    assign gen_mem  = (gen_opnd.kind != OPK_DATA_REG) &&
                      (gen_opnd.kind != OPK_ADDR_REG);
    assign sext_mem = (sext_opnd.kind != OPK_ACC_LOW_BYTE) &&
                      (sext_opnd.kind != OPK_AUX_LOW_BYTE) &&
                      (sext_opnd.kind != OPK_NONE);

    // decode of one request
    always_comb
    begin
        dcd        = '0;
        dcd.form   = req_i.form;
        dcd.opnd   = '{kind: OPK_NONE, reg_sel: 2'h0, ext_bytes: 2'h0};
        unique case (req_i.form)
            FORM_DECIMAL_ADD_RR:
            begin
                dcd.len    = LEN_RR;
                dcd.cycles = CYC_DEC_ADD;
            end
            FORM_DECIMAL_SUB_RR,
            FORM_DECIMAL_SUB_BORROW_RR:
            begin
                dcd.len    = LEN_RR;
                dcd.cycles = CYC_DEC_SUB;
            end
            FORM_DECIMAL_SUB_IMM,
            FORM_DECIMAL_SUB_BORROW_IMM:
            begin
                // word form carries a 16-bit immediate
                dcd.len    = req_i.size_w ? LEN_IMM16 : LEN_IMM8;
                dcd.cycles = CYC_DEC_SUB;
            end
            FORM_FRAME_ALLOC_IMM8:
            begin
                dcd.len    = LEN_IMM8;
                dcd.cycles = CYC_FRAME_ALLOC;
            end
            FORM_DECREMENT_OP_B:
            begin
                unique case (req_i.code[2:0])
                    DCC_ACC_HIGH:
                    begin
                        dcd.opnd.kind = OPK_ACC_HIGH_BYTE;
                        dcd.len       = LEN_DECR_REG;
                        dcd.cycles    = CYC_DECR_REG;
                    end
                    DCC_ACC_LOW:
                    begin
                        dcd.opnd.kind = OPK_ACC_LOW_BYTE;
                        dcd.len       = LEN_DECR_REG;
                        dcd.cycles    = CYC_DECR_REG;
                    end
                    DCC_DSP8_STATIC,
                    DCC_DSP8_FRAME:
                    begin
                        dcd.opnd.kind = (req_i.code[2:0] == DCC_DSP8_STATIC)
                                      ? OPK_DSP8_STATIC_BASE
                                      : OPK_DSP8_FRAME_BASE;
                        dcd.opnd.ext_bytes = 2'h1;
                        dcd.len       = LEN_DECR_DSP;
                        dcd.cycles    = CYC_DECR_MEM;
                    end
                    DCC_ABS16:
                    begin
                        dcd.opnd.kind      = OPK_ABS16;
                        dcd.opnd.ext_bytes = 2'h2;
                        dcd.len       = LEN_DECR_ABS;
                        dcd.cycles    = CYC_DECR_MEM;
                    end
                    default:
                    begin
                        // codes below the accumulator high byte select nothing
                        dcd.undef = 1'b1;
                    end
                endcase
            end
            FORM_DECREMENT_OP_W:
            begin
                dcd.opnd.kind    = OPK_ADDR_REG;
                dcd.opnd.reg_sel = {1'b0, req_i.code[0]};
                dcd.len          = LEN_DECR_REG;
                dcd.cycles       = CYC_DECR_REG;
            end
            FORM_SIGNED_DIVIDE_IMM,
            FORM_EXT_SIGN_DIVIDE_IMM:
            begin
                dcd.is_div = 1'b1;
                dcd.len    = req_i.size_w
                           ? 3'(LEN_DIV_IMM + LEN_WORD_ADD)
                           : LEN_DIV_IMM;
                dcd.cycles = req_i.size_w
                           ? 6'(CYC_SDIV_IMM + CYC_SDIV_W_ADD)
                           : CYC_SDIV_IMM;
            end
            FORM_UNSIGNED_DIVIDE_IMM:
            begin
                dcd.is_div = 1'b1;
                dcd.len    = req_i.size_w
                           ? 3'(LEN_DIV_IMM + LEN_WORD_ADD)
                           : LEN_DIV_IMM;
                dcd.cycles = req_i.size_w
                           ? 6'(CYC_UDIV_IMM + CYC_UDIV_W_ADD)
                           : CYC_UDIV_IMM;
            end
            FORM_SIGNED_DIVIDE_SRC,
            FORM_EXT_SIGN_DIVIDE_SRC:
            begin
                dcd.is_div = 1'b1;
                dcd.opnd   = gen_opnd;
                dcd.len    = 3'(LEN_GEN_BASE + {1'b0, gen_opnd.ext_bytes});
                dcd.cycles = gen_mem ? CYC_SDIV_MEM : CYC_SDIV_REG;
                if (req_i.size_w)
                    dcd.cycles = 6'(dcd.cycles + CYC_SDIV_W_ADD);
            end
            FORM_UNSIGNED_DIVIDE_SRC:
            begin
                dcd.is_div = 1'b1;
                dcd.opnd   = gen_opnd;
                dcd.len    = 3'(LEN_GEN_BASE + {1'b0, gen_opnd.ext_bytes});
                dcd.cycles = gen_mem ? CYC_UDIV_MEM : CYC_UDIV_REG;
                if (req_i.size_w)
                    dcd.cycles = 6'(dcd.cycles + CYC_UDIV_W_ADD);
            end
            FORM_FRAME_RELEASE_RETURN:
            begin
                dcd.len    = LEN_EXIT;
                dcd.cycles = CYC_EXIT;
            end
            FORM_SIGN_EXTEND_OP_B:
            begin
                dcd.opnd   = sext_opnd;
                dcd.undef  = sext_undef;
                dcd.len    = 3'(LEN_GEN_BASE + {1'b0, sext_opnd.ext_bytes});
                dcd.cycles = sext_mem ? CYC_SEXT_MEM : CYC_SEXT_REG;
            end
        endcase
        // an undefined instruction carries no length or timing
        if (dcd.undef)
        begin
            dcd.len    = '0;
            dcd.cycles = '0;
        end
    end

    // sequencing
    always_comb
    begin
        s_d        = s_q;
        s_d.accept = 1'b0;
        s_d.done   = 1'b0;
        unique case (s_q.st)
            ST_IDLE:
            begin
                if (req_i.valid)
                begin
                    s_d.res    = dcd;
                    s_d.accept = 1'b1;
                    s_d.early  = 1'b0;
                    if (dcd.undef)
                        s_d.done = 1'b1;
                    else
                    begin
                        s_d.st  = ST_RUN;
                        s_d.cnt = dcd.cycles;
                    end
                end
            end
            ST_RUN:
            begin
                if (s_q.res.is_div && early_stop_i && s_q.cnt != 6'h01)
                begin
                    s_d.st    = ST_IDLE;
                    s_d.cnt   = '0;
                    s_d.done  = 1'b1;
                    s_d.early = 1'b1;
                end
                else if (s_q.cnt == 6'h01)
                begin
                    s_d.st   = ST_IDLE;
                    s_d.cnt  = '0;
                    s_d.done = 1'b1;
                end
                else
                    s_d.cnt = 6'(s_q.cnt - 6'h01);
            end
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            s_q <= '{st: ST_IDLE, cnt: '0, res: '0,
                     accept: 1'b0, done: 1'b0, early: 1'b0};
        else
            s_q <= s_d;
    end

    assign busy_o   = (s_q.st == ST_RUN);
    assign accept_o = s_q.accept;
    assign done_o   = s_q.done;
    assign early_o  = s_q.early;
    assign dcd_o    = s_q.res;
    assign remain_o = s_q.cnt;

endmodule : cocd_decoder

`default_nettype wire

// File: dv/cocd_decoder_monitor.sv
/* cocd_decoder_monitor: timing assertions on the decoder ports.
   assumes: bound into cocd_decoder; one clock, synchronous reset. */
`timescale 1ns/10ps
`default_nettype none
module cocd_decoder_monitor (
    input wire logic                    core_clk_i,
    input wire logic                    rst_i,
    input wire cocd_pkg::cocd_req_s     req_i,
    input wire logic                    early_stop_i,
    input wire logic                    busy_o,
    input wire logic                    accept_o,
    input wire logic                    done_o,
    input wire logic                    early_o,
    input wire cocd_pkg::cocd_dcd_s     dcd_o,
    input wire logic [cocd_pkg::CYC_W-1:0] remain_o
);
    import cocd_pkg::*;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_take;
        !busy_o && req_i.valid;
    endsequence
    sequence s_last;
        busy_o && remain_o == 6'h01;
    endsequence
    sequence s_stop;
        busy_o && dcd_o.is_div && early_stop_i && remain_o != 6'h01;
    endsequence
    take_accept_a: assert property (s_take |=> accept_o)
        else $error("request taken but not accepted");
    accept_cause_a: assert property (accept_o |-> !$past(busy_o))
        else $error("accept while busy");
    load_count_a: assert property (accept_o && !dcd_o.undef
        |-> busy_o && remain_o == dcd_o.cycles)
        else $error("counter not loaded with cycle count");
    count_down_a: assert property (busy_o && remain_o > 6'h01
        && !(early_stop_i && dcd_o.is_div)
        |=> busy_o && remain_o == $past(remain_o) - 6'h01)
        else $error("counter did not step down");
    last_finish_a: assert property (s_last |=> done_o && !busy_o
        && remain_o == 6'h00)
        else $error("no completion after last cycle");
    undef_done_a: assert property (accept_o && dcd_o.undef
        |-> done_o && !busy_o && dcd_o.len == 3'h0 && dcd_o.cycles == 6'h00)
        else $error("undefined form not closed at once");
    early_end_a: assert property (s_stop
        |=> done_o && early_o && !busy_o)
        else $error("early stop not honoured");
    no_early_a: assert property (busy_o && !dcd_o.is_div |=> !early_o)
        else $error("early flag on non divide");
    sext_undef_a: assert property (accept_o
        && dcd_o.form == FORM_SIGN_EXTEND_OP_B |-> dcd_o.undef ==
        ($past(req_i.code) inside {4'h1, 4'h3, 4'h4, 4'h5}))
        else $error("sign extend register code misjudged");
endmodule : cocd_decoder_monitor

bind cocd_decoder cocd_decoder_monitor u_monitor (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .req_i       (req_i),
    .early_stop_i(early_stop_i),
    .busy_o      (busy_o),
    .accept_o    (accept_o),
    .done_o      (done_o),
    .early_o     (early_o),
    .dcd_o       (dcd_o),
    .remain_o    (remain_o)
);
`default_nettype wire

// File: dv/cocd_prog_feed.sv
/* cocd_prog_feed: program memory model presenting one request at a time.
   assumes: loaded on the falling edge; drops the request once taken. */
`timescale 1ns/10ps
`default_nettype none
module cocd_prog_feed (
    input  wire logic                core_clk_i,
    input  wire logic                rst_i,
    input  wire logic                load_i,
    input  wire cocd_pkg::cocd_req_s next_i,
    input  wire logic                busy_i,
    output var cocd_pkg::cocd_req_s  req_o
);
    import cocd_pkg::*;
    logic taken_q;
    initial req_o = '0;
    always @(posedge core_clk_i)
        taken_q <= req_o.valid && !busy_i && !rst_i;
    // released lines show the inverse of the last value
    always @(negedge core_clk_i)
        if (load_i)
            req_o <= next_i;
        else if (taken_q)
            req_o <= cocd_req_s'({1'b0, ~req_o[8:0]});
endmodule : cocd_prog_feed
`default_nettype wire

// File: dv/testbench.sv
/* testbench: runs the opcode cycle decoder through the feed model.
   assumes: 100 MHz clock, synchronous reset, inputs on falling edge. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import cocd_pkg::*;
    logic             core_clk_i, rst_i, early_stop_i, load;
    logic             busy_o, accept_o, done_o, early_o;
    cocd_req_s        next_req, req;
    cocd_dcd_s        dcd_o;
    logic [CYC_W-1:0] remain_o;
    int               errors, checks_done, cyc;
    cocd_prog_feed feed (
        .core_clk_i(core_clk_i),
        .rst_i     (rst_i),
        .load_i    (load),
        .next_i    (next_req),
        .busy_i    (busy_o),
        .req_o     (req)
    );
    cocd_decoder uut (
        .core_clk_i  (core_clk_i),
        .rst_i       (rst_i),
        .req_i       (req),
        .early_stop_i(early_stop_i),
        .busy_o      (busy_o),
        .accept_o    (accept_o),
        .done_o      (done_o),
        .early_o     (early_o),
        .dcd_o       (dcd_o),
        .remain_o    (remain_o)
    );
    initial
    begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            errors++;
            conclude();
        end
    end
    task automatic conclude();
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude
    task automatic chk(input string w, input logic [7:0] e, logic [7:0] g);
        checks_done++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH %s expected %0h seen %0h", w, e, g);
        end
    endtask : chk
    // one instruction: l/n expected length/cycles, m busy cycles
    task automatic op(input cocd_form_e f, input logic s, input logic [3:0] c,
                      input cocd_opk_e k, input int l, input int n,
                      input int m, input int stop);
        int b;
        logic [1:0] rs;
        logic [1:0] eb;
        logic dv;
        @(negedge core_clk_i);
        load <= 1'b1;
        next_req <= '{valid: 1'b1, form: f, size_w: s, code: c};
        @(negedge core_clk_i);
        load <= 1'b0;
        b = 0;
        while (accept_o !== 1'b1 && b < 4)
        begin
            @(negedge core_clk_i);
            b++;
        end
        chk("accept", 8'h01, {7'h0, accept_o});
        chk("len", l[7:0], {5'h0, dcd_o.len});
        chk("cycles", n[7:0], {2'h0, dcd_o.cycles});
        chk("undef", {7'h0, l == 0}, {7'h0, dcd_o.undef});
        rs = (k == OPK_DATA_REG) ? c[1:0] : 2'h0;
        if (k inside {OPK_ADDR_REG, OPK_INDIRECT, OPK_DSP8_ADDR,
                      OPK_DSP16_ADDR})
            rs = {1'b0, c[0]};
        eb = (k inside {OPK_DSP8_ADDR, OPK_DSP8_STATIC_BASE,
                        OPK_DSP8_FRAME_BASE}) ? 2'h1 : 2'h0;
        if (k inside {OPK_DSP16_ADDR, OPK_DSP16_STATIC_BASE, OPK_ABS16})
            eb = 2'h2;
        dv = f inside {FORM_SIGNED_DIVIDE_IMM, FORM_SIGNED_DIVIDE_SRC,
                       FORM_EXT_SIGN_DIVIDE_IMM, FORM_EXT_SIGN_DIVIDE_SRC,
                       FORM_UNSIGNED_DIVIDE_IMM, FORM_UNSIGNED_DIVIDE_SRC};
        chk("form", {4'h0, f}, {4'h0, dcd_o.form});
        chk("is_div", {7'h0, dv}, {7'h0, dcd_o.is_div});
        if (k != OPK_NONE)
        begin
            chk("kind", {4'h0, k}, {4'h0, dcd_o.opnd.kind});
            chk("reg_sel", {6'h0, rs}, {6'h0, dcd_o.opnd.reg_sel});
            chk("ext_bytes", {6'h0, eb}, {6'h0, dcd_o.opnd.ext_bytes});
        end
        b = 0;
        while (busy_o === 1'b1 && b < 40)
        begin
            b++;
            early_stop_i <= (b == stop);
            @(negedge core_clk_i);
        end
        early_stop_i <= 1'b0;
        chk("busy_cycles", m[7:0], b[7:0]);
        chk("done", 8'h01, {7'h0, done_o});
        chk("early", {7'h0, m != n}, {7'h0, early_o});
    endtask : op
    task automatic t_decimal();
        op(FORM_DECIMAL_ADD_RR,0,0,OPK_NONE,2,5,5,0);
        op(FORM_DECIMAL_SUB_RR,1,0,OPK_NONE,2,4,4,0);
        op(FORM_DECIMAL_SUB_BORROW_RR,0,0,OPK_NONE,2,4,4,0);
        op(FORM_DECIMAL_SUB_IMM,0,0,OPK_NONE,3,4,4,0);
        op(FORM_DECIMAL_SUB_BORROW_IMM,1,0,OPK_NONE,4,4,4,0);
        op(FORM_FRAME_ALLOC_IMM8,0,0,OPK_NONE,3,4,4,0);
        op(FORM_FRAME_RELEASE_RETURN,0,0,OPK_NONE,2,9,9,0);
        $display("test decimal done");
    endtask : t_decimal
    task automatic t_decrement();
        op(FORM_DECREMENT_OP_B,0,3,OPK_ACC_HIGH_BYTE,1,1,1,0);
        op(FORM_DECREMENT_OP_B,0,4,OPK_ACC_LOW_BYTE,1,1,1,0);
        op(FORM_DECREMENT_OP_B,0,5,OPK_DSP8_STATIC_BASE,2,3,3,0);
        op(FORM_DECREMENT_OP_B,0,6,OPK_DSP8_FRAME_BASE,2,3,3,0);
        op(FORM_DECREMENT_OP_B,0,7,OPK_ABS16,3,3,3,0);
        op(FORM_DECREMENT_OP_B,0,1,OPK_NONE,0,0,0,0);
        op(FORM_DECREMENT_OP_W,0,1,OPK_ADDR_REG,1,1,1,0);
        $display("test decrement done");
    endtask : t_decrement
    task automatic t_divide();
        op(FORM_SIGNED_DIVIDE_SRC,0,0,OPK_DATA_REG,2,22,22,0);
        op(FORM_SIGNED_DIVIDE_SRC,0,6,OPK_INDIRECT,2,24,24,0);
        op(FORM_SIGNED_DIVIDE_SRC,1,8,OPK_DSP8_ADDR,3,30,30,0);
        op(FORM_EXT_SIGN_DIVIDE_SRC,1,5,OPK_ADDR_REG,2,28,28,0);
        op(FORM_SIGNED_DIVIDE_IMM,1,0,OPK_NONE,4,28,28,0);
        op(FORM_EXT_SIGN_DIVIDE_IMM,0,0,OPK_NONE,3,22,22,0);
        op(FORM_UNSIGNED_DIVIDE_IMM,0,0,OPK_NONE,3,18,18,0);
        op(FORM_UNSIGNED_DIVIDE_IMM,1,0,OPK_NONE,4,25,25,0);
        op(FORM_UNSIGNED_DIVIDE_SRC,0,4,OPK_ADDR_REG,2,18,18,0);
        op(FORM_UNSIGNED_DIVIDE_SRC,1,15,OPK_ABS16,4,27,27,0);
        $display("test divide done");
    endtask : t_divide
    task automatic t_early();
        op(FORM_UNSIGNED_DIVIDE_SRC,0,0,OPK_DATA_REG,2,18,5,5);
        op(FORM_DECIMAL_ADD_RR,0,0,OPK_NONE,2,5,5,2);
        op(FORM_SIGNED_DIVIDE_IMM,0,0,OPK_NONE,3,22,22,22);
        $display("test early stop done");
    endtask : t_early
    task automatic t_sign_extend();
        op(FORM_SIGN_EXTEND_OP_B,0,0,OPK_ACC_LOW_BYTE,2,3,3,0);
        op(FORM_SIGN_EXTEND_OP_B,0,2,OPK_AUX_LOW_BYTE,2,3,3,0);
        op(FORM_SIGN_EXTEND_OP_B,0,7,OPK_INDIRECT,2,5,5,0);
        op(FORM_SIGN_EXTEND_OP_B,0,14,OPK_DSP16_STATIC_BASE,4,5,5,0);
        for (int i = 1; i < 6; i++)
            if (i != 2)
                op(FORM_SIGN_EXTEND_OP_B,0,i[3:0],OPK_NONE,0,0,0,0);
        $display("test sign extend done");
    endtask : t_sign_extend
    initial
    begin
        rst_i = 1'b1;
        early_stop_i = 1'b0;
        load = 1'b0;
        next_req = '0;
        repeat (4) @(negedge core_clk_i);
        chk("reset_busy", 8'h00, {7'h0, busy_o});
        chk("reset_remain", 8'h00, {2'h0, remain_o});
        rst_i <= 1'b0;
        t_decimal();
        t_decrement();
        t_divide();
        t_early();
        t_sign_extend();
        conclude();
    end
endmodule : testbench
`default_nettype wire
